// ### core/gpio_cmd_regs.svh
`ifndef GPIO_CMD_REGS_SVH
`define GPIO_CMD_REGS_SVH

// Command codes
`define CMD_QUERY_AVAIL   8'h10
`define CMD_SET_POLARITY  8'h1A
`define CMD_SET_STATE     8'h1B

// Frame geometry in bytes
`define FRAME_PARAM_BYTES 4'd8
`define REPLY_BYTES       3'd5

// Register byte offsets
`define REG_AVAIL_OFS     12'h000
`define REG_OUTEN_OFS     12'h004
`define REG_CTRL_OFS      12'h008
`define REG_POLARITY_OFS  12'h00C
`define REG_STATE_OFS     12'h010
`define REG_PINS_OFS      12'h014
`define REG_STATUS_OFS    12'h018
`define REG_FRAMES_OFS    12'h01C

// Control fields
`define CTRL_ENABLE_BIT   0
`define CTRL_RESET_VAL    32'h0000_0001

// Reset values
`define AVAIL_RESET_VAL   32'h0000_0000
`define OUTEN_RESET_VAL   32'h0000_0000
`define POL_RESET_VAL     32'h0000_0000
`define STATE_RESET_VAL   32'h0000_0000

`endif

// ### core/gpio_cmd_pkg.sv
package gpio_cmd_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [31:0] word_t;
  typedef logic [11:0] addr_t;

  // Reply serializer states
  typedef enum logic [1:0]
  {
    SER_IDLE = 2'b01,
    SER_SEND = 2'b10
  } ser_state_e;

  // Frame assembler states
  typedef enum logic [2:0]
  {
    ASM_CODE  = 3'b001,
    ASM_PARAM = 3'b010,
    ASM_WAIT  = 3'b100
  } asm_state_e;
endpackage : gpio_cmd_pkg

// ### core/frame_if.sv
`timescale 1ns/10ps
interface frame_if;
  import gpio_cmd_pkg::*;
  logic  frameValid;
  byte_t cmdCode;
  word_t maskWord;
  word_t valueWord;
  logic  replyValid;
  byte_t replyCode;
  word_t replyWord;
  logic  replyDone;

  modport assembler
  (
    output frameValid, cmdCode, maskWord, valueWord,
    input  replyDone
  );
  modport core
  (
    input  frameValid, cmdCode, maskWord, valueWord,
    output replyValid, replyCode, replyWord
  );
  modport serializer
  (
    input  replyValid, replyCode, replyWord,
    output replyDone
  );
endinterface : frame_if

// ### core/frame_assembler.sv
`timescale 1ns/10ps
`include "gpio_cmd_regs.svh"
module frame_assembler
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  enable,
  input  wire logic                  rxValid,
  input  wire gpio_cmd_pkg::byte_t   rxData,
  output logic                       rxReady,
  frame_if.assembler                 frm
);
  import gpio_cmd_pkg::*;

  asm_state_e        state_ff;
  logic [3:0]        count_ff;
  logic [63:0]       params_ff;
  byte_t             code_ff;
  logic              valid_ff;
  logic              ready_ff;
  logic              take;

  assign take       = rxValid & ready_ff;
  assign rxReady    = ready_ff;
  assign frm.frameValid = valid_ff;
  assign frm.cmdCode    = code_ff;
  assign frm.maskWord   = params_ff[31:0];
  assign frm.valueWord  = params_ff[63:32];

  // Byte collection: code first, then eight parameter bytes
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff  <= ASM_CODE;
      count_ff  <= 4'h0;
      params_ff <= 64'h0000_0000_0000_0000;
      code_ff   <= 8'h00;
      valid_ff  <= 1'b0;
    end
    else
    begin
      valid_ff <= 1'b0;
      case (state_ff)
        ASM_CODE:
        begin
          if (take)
          begin
            code_ff  <= rxData;
            count_ff <= 4'h0;
            state_ff <= ASM_PARAM;
          end
        end
        ASM_PARAM:
        begin
          if (take)
          begin
            params_ff <= {rxData, params_ff[63:8]};  // LSB first
            count_ff  <= count_ff + 4'h1;
            if (count_ff == `FRAME_PARAM_BYTES - 4'd1)
            begin
              valid_ff <= 1'b1;
              state_ff <= ASM_WAIT;
            end
          end
        end
        ASM_WAIT:
        begin
          if (frm.replyDone)
            state_ff <= ASM_CODE;
        end
        default:
          state_ff <= ASM_CODE;
      endcase
    end
  end

  // Accept bytes only while collecting and enabled
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ready_ff <= 1'b0;
    else
      ready_ff <= enable & (state_ff != ASM_WAIT)
                  & ~(take & (state_ff == ASM_PARAM)
                      & (count_ff == `FRAME_PARAM_BYTES - 4'd1));
  end
endmodule : frame_assembler

// ### core/reply_serializer.sv
`timescale 1ns/10ps
`include "gpio_cmd_regs.svh"
module reply_serializer
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  output logic                       txValid,
  output gpio_cmd_pkg::byte_t        txData,
  input  wire logic                  txReady,
  frame_if.serializer                frm
);
  import gpio_cmd_pkg::*;

  ser_state_e   state_ff;
  logic [39:0]  shift_ff;
  logic [2:0]   left_ff;
  logic         done_ff;
  logic         valid_ff;

  // Valid comes from its own flop so the pin is registered
  assign txValid       = valid_ff;
  assign txData        = shift_ff[7:0];
  assign frm.replyDone = done_ff;

  // Sends code byte, then the word low byte first
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= SER_IDLE;
      shift_ff <= 40'h00_0000_0000;
      left_ff  <= 3'h0;
      done_ff  <= 1'b0;
      valid_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      case (state_ff)
        SER_IDLE:
        begin
          if (frm.replyValid)
          begin
            shift_ff <= {frm.replyWord, frm.replyCode};  // Echo code first
            left_ff  <= `REPLY_BYTES;                    // Five bytes
            state_ff <= SER_SEND;
            valid_ff <= 1'b1;
          end
        end
        SER_SEND:
        begin
          if (txReady)
          begin
            shift_ff <= {8'h00, shift_ff[39:8]};
            left_ff  <= left_ff - 3'h1;
            if (left_ff == 3'h1)
            begin
              state_ff <= SER_IDLE;
              done_ff  <= 1'b1;
              valid_ff <= 1'b0;
            end
          end
        end
        default:
          state_ff <= SER_IDLE;
      endcase
    end
  end
endmodule : reply_serializer

// ### core/gpio_command_handler.sv
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "gpio_cmd_regs.svh"
module gpio_command_handler
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire gpio_cmd_pkg::addr_t   paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire gpio_cmd_pkg::word_t   pwdata,
  output gpio_cmd_pkg::word_t        prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  rxValid,
  input  wire gpio_cmd_pkg::byte_t   rxData,
  output logic                       rxReady,
  output logic                       txValid,
  output gpio_cmd_pkg::byte_t        txData,
  input  wire logic                  txReady,
  input  wire gpio_cmd_pkg::word_t   gpioIn,
  output gpio_cmd_pkg::word_t        gpioOut,
  output gpio_cmd_pkg::word_t        gpioOe_n
);
  import gpio_cmd_pkg::*;

  frame_if frm ();

  // Stored configuration, pin and reply state
  word_t       avail_ff;
  word_t       outEn_ff;
  logic [31:0] ctrl_ff;
  word_t       polarity_ff;
  word_t       state_ff;
  word_t       pinMeta_ff;
  word_t       pinSync_ff;
  word_t       gpioOut_ff;
  word_t       gpioOe_n_ff;
  logic        replyValid_ff;
  byte_t       replyCode_ff;
  word_t       replyWord_ff;
  byte_t       lastCode_ff;
  logic        unknownSeen_ff;
  logic [15:0] frames_ff;

  // Bus answer flops and next-value terms
  word_t       prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  word_t       nxt_polarity;
  word_t       nxt_state;
  word_t       nxt_rdata;
  logic        nxt_err;

  // Decode strobes
  logic        apbAccess;
  logic        apbWrite;
  logic        isPol;
  logic        isState;
  logic        isQuery;
  logic        isUnknown;

  // Masked update limited to general-purpose pins
  function automatic word_t apply_masked(input word_t old, input word_t mask,
                                         input word_t val, input word_t avail);
    word_t sel;
    sel = mask & avail;
    return (old & ~sel) | (val & sel);
  endfunction : apply_masked

  // Write strobe for one register offset
  function automatic logic wr_hit(input logic wr, input addr_t a, input addr_t ofs);
    return wr & (a == ofs);
  endfunction : wr_hit

  // Byte collection from the host link
  frame_assembler u_asm
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .enable  (ctrl_ff[`CTRL_ENABLE_BIT]),
    .rxValid (rxValid),
    .rxData  (rxData),
    .rxReady (rxReady),
    .frm     (frm.assembler)
  );

  // Reply transmission to the host link
  reply_serializer u_ser
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .txValid (txValid),
    .txData  (txData),
    .txReady (txReady),
    .frm     (frm.serializer)
  );

  // Command decode
  assign isPol   = frm.frameValid & (frm.cmdCode == `CMD_SET_POLARITY);
  assign isState = frm.frameValid & (frm.cmdCode == `CMD_SET_STATE);
  assign isQuery = frm.frameValid & (frm.cmdCode == `CMD_QUERY_AVAIL);
  assign isUnknown = frm.frameValid & ~(isPol | isState | isQuery);

  // Next polarity vector
  always_comb
  begin
    nxt_polarity = polarity_ff;
    if (isPol)
      nxt_polarity = apply_masked(polarity_ff, frm.maskWord, frm.valueWord,
                                  avail_ff);
  end

  // Next state vector
  always_comb
  begin
    nxt_state = state_ff;
    if (isState)
      nxt_state = apply_masked(state_ff, frm.maskWord, frm.valueWord,
                               avail_ff);
  end

  // Polarity storage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      polarity_ff <= `POL_RESET_VAL;
    else
      polarity_ff <= nxt_polarity;
  end

  // State storage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= `STATE_RESET_VAL;
    else
      state_ff <= nxt_state;
  end

  // Reply strobe, one cycle after the frame is decoded
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      replyValid_ff <= 1'b0;
    else
      replyValid_ff <= frm.frameValid;
  end

  // Echoed command code
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      replyCode_ff <= 8'h00;
    else if (frm.frameValid)
      replyCode_ff <= frm.cmdCode;
  end

  // Reply word, parameters of the query ignored
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      replyWord_ff <= 32'h0000_0000;
    else if (isQuery)
      replyWord_ff <= avail_ff;
    else if (isPol)
      replyWord_ff <= nxt_polarity & avail_ff;
    else if (isState)
      replyWord_ff <= nxt_state & avail_ff;
    else if (isUnknown)
      replyWord_ff <= 32'h0000_0000;                       // Unknown code answers zero
  end

  // Reply towards the serializer
  assign frm.replyValid = replyValid_ff;
  assign frm.replyCode  = replyCode_ff;
  assign frm.replyWord  = replyWord_ff;

  // Last command code for software
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      lastCode_ff <= 8'h00;
    else if (frm.frameValid)
      lastCode_ff <= frm.cmdCode;
  end

  // Frame counter, wraps at its width
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      frames_ff <= 16'h0000;
    else if (frm.frameValid)
      frames_ff <= frames_ff + 16'h0001;
  end

  // Unknown-code flag: set wins over a simultaneous software clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      unknownSeen_ff <= 1'b0;
    else if (isUnknown)
      unknownSeen_ff <= 1'b1;
    else if (wr_hit(apbWrite, paddr, `REG_STATUS_OFS) & pwdata[8])
      unknownSeen_ff <= 1'b0;
  end

  // Pin drive level: the active state honours polarity
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      gpioOut_ff <= 32'h0000_0000;
    else
      gpioOut_ff <= state_ff ^ polarity_ff;
  end

  // Pin enable: special-function pins are never driven
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      gpioOe_n_ff <= 32'hFFFF_FFFF;
    else
      gpioOe_n_ff <= ~(outEn_ff & avail_ff);
  end

  // Pins straight from their flops
  assign gpioOut  = gpioOut_ff;
  assign gpioOe_n = gpioOe_n_ff;

  // Pin input synchroniser, first stage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pinMeta_ff <= 32'h0000_0000;
    else
      pinMeta_ff <= gpioIn;
  end

  // Second stage, the only reader of the first
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pinSync_ff <= 32'h0000_0000;
    else
      pinSync_ff <= pinMeta_ff;
  end

  // APB phases: answer one cycle into the access phase
  assign apbAccess = psel & penable & ~pready_ff;
  assign apbWrite  = psel & penable & pready_ff & pwrite & ~pslverr_ff;

  // Pin availability map
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      avail_ff <= `AVAIL_RESET_VAL;
    else if (wr_hit(apbWrite, paddr, `REG_AVAIL_OFS))
      avail_ff <= pwdata;
  end

  // Output enable map
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      outEn_ff <= `OUTEN_RESET_VAL;
    else if (wr_hit(apbWrite, paddr, `REG_OUTEN_OFS))
      outEn_ff <= pwdata;
  end

  // Control: only the enable bit is kept
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_ff <= `CTRL_RESET_VAL;
    else if (wr_hit(apbWrite, paddr, `REG_CTRL_OFS))
      ctrl_ff <= {31'h0000_0000, pwdata[`CTRL_ENABLE_BIT]};
  end

  // Read mux and unmapped decode
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    nxt_err   = 1'b0;
    case (paddr)
      `REG_AVAIL_OFS:    nxt_rdata = avail_ff;
      `REG_OUTEN_OFS:    nxt_rdata = outEn_ff;
      `REG_CTRL_OFS:     nxt_rdata = ctrl_ff;
      `REG_POLARITY_OFS: nxt_rdata = polarity_ff & avail_ff;
      `REG_STATE_OFS:    nxt_rdata = state_ff & avail_ff;
      `REG_PINS_OFS:     nxt_rdata = pinSync_ff & avail_ff;
      `REG_STATUS_OFS:   nxt_rdata = {23'h00_0000, unknownSeen_ff, lastCode_ff};
      `REG_FRAMES_OFS:   nxt_rdata = {16'h0000, frames_ff};
      default:           nxt_err   = 1'b1;
    endcase
  end

  // Ready pulse one cycle into the access phase
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pready_ff <= 1'b0;
    else
      pready_ff <= apbAccess;
  end

  // Error flag with ready for an unmapped offset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pslverr_ff <= 1'b0;
    else
      pslverr_ff <= apbAccess & nxt_err;
  end

  // Read data, held only in the ready cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata_ff <= 32'h0000_0000;
    else if (apbAccess & ~pwrite)
      prdata_ff <= nxt_rdata;
    else if (pready_ff)
      prdata_ff <= 32'h0000_0000;
  end

  // Bus answer from its flops
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata  = prdata_ff;
endmodule : gpio_command_handler

// ### verif/gpio_cmd_checker.sv
`timescale 1ns/10ps
module gpio_cmd_checker
(
  input wire logic                ref_clk,
  input wire logic                rst_n,
  input wire logic                rxValid,
  input wire gpio_cmd_pkg::byte_t rxData,
  input wire logic                rxReady,
  input wire logic                txValid,
  input wire gpio_cmd_pkg::byte_t txData,
  input wire logic                txReady,
  input wire gpio_cmd_pkg::word_t gpioOut
);
  import gpio_cmd_pkg::*;
  logic [3:0] rxCnt_ff;
  logic [2:0] txCnt_ff;
  byte_t      code_ff;
  word_t      mask_ff;
  logic       rxTake;
  logic       txTake;
  // Byte moves on each link
  assign rxTake = rxValid && rxReady;
  assign txTake = txValid && txReady;
  // Position within the incoming frame
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) rxCnt_ff <= 4'h0;
    else if (rxTake) rxCnt_ff <= (rxCnt_ff == 4'h8) ? 4'h0 : rxCnt_ff + 4'h1;
  // Code and mask of the current frame
  always_ff @(posedge ref_clk)
  begin
    if (rxTake && rxCnt_ff == 4'h0) code_ff <= rxData;
    if (rxTake && rxCnt_ff >= 4'h1 && rxCnt_ff <= 4'h4)
      mask_ff[8*(rxCnt_ff-4'h1) +: 8] <= rxData;
  end
  // Position within the reply
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) txCnt_ff <= 3'h0;
    else if (txTake) txCnt_ff <= (txCnt_ff == 3'h4) ? 3'h0 : txCnt_ff + 3'h1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_REPLY_CODE: assert property (txValid && txCnt_ff == 3'h0 |-> txData == code_ff)
    else $error("reply does not open with the command code");
  AST_RX_STOP: assert property (rxTake && rxCnt_ff == 4'h8 |=> !rxReady)
    else $error("bytes still accepted after a whole frame");
  AST_REPLY_START: assert property (rxTake && rxCnt_ff == 4'h8 |=> !txValid [*2] ##1 txValid)
    else $error("reply start late or early");
  AST_REPLY_END: assert property (txTake && txCnt_ff == 3'h4 |=> !txValid && !rxReady ##1 !rxReady ##1 rxReady)
    else $error("reply not five bytes long");
  AST_TX_HOLD: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("reply byte dropped while stalled");
  AST_RX_BUSY: assert property (txValid |-> !rxReady)
    else $error("command bytes accepted during reply");
  AST_MASKED_HOLD: assert property (((gpioOut ^ $past(gpioOut)) & ~mask_ff) == 32'h0000_0000)
    else $error("pin changed outside the mask");
  AST_IDLE_STABLE: assert property (rxReady |-> $stable(gpioOut))
    else $error("pins changed before a frame completed");
endmodule : gpio_cmd_checker

bind gpio_command_handler gpio_cmd_checker chk_u
(
  .ref_clk (ref_clk),
  .rst_n   (rst_n),
  .rxValid (rxValid),
  .rxData  (rxData),
  .rxReady (rxReady),
  .txValid (txValid),
  .txData  (txData),
  .txReady (txReady),
  .gpioOut (gpioOut)
);

// ### verif/host_model.sv
`timescale 1ns/10ps
module host_model
(
  input  wire logic                ref_clk,
  input  wire logic                rxReady,
  input  wire logic                txValid,
  input  wire gpio_cmd_pkg::byte_t txData,
  input  wire logic                stall,
  output logic                     rxValid,
  output gpio_cmd_pkg::byte_t      rxData,
  output logic                     txReady
);
  import gpio_cmd_pkg::*;
  // Idle link at time zero
  initial
  begin
    rxValid = 1'b0;
    rxData  = 8'h00;
    txReady = 1'b0;
  end
  // Sink readiness, withdrawn at random when stalling
  always @(posedge ref_clk) txReady <= stall ? 1'($urandom_range(0, 1)) : 1'b1;
  // One frame out, one reply in; words travel low byte first
  task automatic do_frame(input byte_t code, input word_t m, input word_t v,
                          output byte_t rcode, output word_t rword);
    logic [71:0] frm;
    logic [39:0] rep;
    frm = {v, m, code};
    @(posedge ref_clk);
    for (int i = 0; i < 9; i++)
    begin
      rxValid <= 1'b1;
      rxData  <= frm[8*i +: 8];
      @(posedge ref_clk);
      while (!rxReady) @(posedge ref_clk);
    end
    rxValid <= 1'b0;
    rxData  <= ~frm[71:64]; // Released line shows no stale byte
    for (int j = 0; j < 5; j++)
    begin
      do @(posedge ref_clk); while (!(txValid && txReady));
      rep[8*j +: 8] = txData;
    end
    rcode = rep[7:0];
    rword = rep[39:8];
  endtask : do_frame
endmodule : host_model

// ### verif/test_gpio_command_handler.sv
`timescale 1ns/10ps
`include "gpio_cmd_regs.svh"
module test_gpio_command_handler;
  import gpio_cmd_pkg::*;
  logic  ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, uk;
  logic  rxValid, rxReady, txValid, txReady, stall;
  addr_t paddr;
  word_t pwdata, prdata, gpioIn, gpioOut, gpioOe_n, av, oe, pol, st, rd, rw, ex;
  byte_t rxData, txData, rc, lc;
  byte_t codes [4] = '{`CMD_QUERY_AVAIL, `CMD_SET_POLARITY, `CMD_SET_STATE, 8'h55};
  int    num_errors, num_checks, nf;
  // Free-running bench clock
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  gpio_command_handler dut_u
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .txValid(txValid),
    .txData(txData), .txReady(txReady), .gpioIn(gpioIn), .gpioOut(gpioOut),
    .gpioOe_n(gpioOe_n)
  );
  host_model host_u
  (
    .ref_clk(ref_clk), .rxReady(rxReady), .txValid(txValid), .txData(txData),
    .stall(stall), .rxValid(rxValid), .rxData(rxData), .txReady(txReady)
  );
  // Word comparison
  task chk(input string name, input word_t exp, input word_t got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One APB transfer, held until pready
  task apb(input logic wr, input addr_t a, input word_t d, output word_t r, output logic e);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Masked update of available pins
  function word_t upd(input word_t old, input word_t mk, input word_t val);
    return (old & ~(mk & av)) | (val & mk & av);
  endfunction : upd
  // Send a frame and check reply and pins
  task frame(input byte_t c, input word_t mk, input word_t val);
    host_u.do_frame(c, mk, val, rc, rw);
    nf++;
    lc = c;
    case (c)
      `CMD_QUERY_AVAIL:  ex = av;
      `CMD_SET_POLARITY: begin pol = upd(pol, mk, val); ex = pol & av; end
      `CMD_SET_STATE:    begin st = upd(st, mk, val); ex = st & av; end
      default:           begin ex = 32'h0000_0000; uk = 1'b1; end
    endcase
    chk("reply code", {24'h0, c}, {24'h0, rc});
    chk("reply word", ex, rw);
    chk("pin drive", st ^ pol, gpioOut);
  endtask : frame
  // Verdict and end of run
  task final_report;
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  // Watchdog
  initial
  begin
    #500000;
    num_errors++;
    final_report();
  end
  // Main sequence
  initial
  begin
    {rst_n, psel, penable, pwrite, stall} = 5'b00000;
    paddr  = 12'h000;
    pwdata = 32'h0000_0000;
    gpioIn = 32'h0000_0000;
    {pol, st, num_errors, num_checks, nf, uk} = '0;
    void'($urandom(99736));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("oe reset", 32'hFFFF_FFFF, gpioOe_n);
    av = $urandom | 32'h0000_0203;
    oe = $urandom;
    apb(1'b1, `REG_AVAIL_OFS, av, rd, err);
    apb(1'b1, `REG_OUTEN_OFS, oe, rd, err);
    apb(1'b0, `REG_AVAIL_OFS, 32'h0000_0000, rd, err);
    chk("avail", av, rd);
    apb(1'b0, 12'h020, 32'h0000_0000, rd, err);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    chk("oe", ~(av & oe), gpioOe_n);
    gpioIn <= $urandom;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, `REG_PINS_OFS, 32'h0000_0000, rd, err);
    chk("pins", gpioIn & av, rd);
    frame(`CMD_QUERY_AVAIL, $urandom, $urandom);
    frame(`CMD_SET_STATE, 32'h0000_0201, 32'h0000_0001);
    frame(`CMD_SET_POLARITY, 32'hFFFF_FFFF, $urandom);
    frame(`CMD_SET_STATE, 32'h0000_0000, 32'hFFFF_FFFF);
    frame(8'h55, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    for (int i = 0; i < 16; i++)
    begin
      stall <= i[0];
      frame(codes[$urandom_range(0, 3)], $urandom, $urandom);
    end
    apb(1'b0, `REG_POLARITY_OFS, 32'h0000_0000, rd, err);
    chk("polarity", pol & av, rd);
    apb(1'b0, `REG_STATE_OFS, 32'h0000_0000, rd, err);
    chk("state", st & av, rd);
    apb(1'b0, `REG_STATUS_OFS, 32'h0000_0000, rd, err);
    chk("status", {23'h0, uk, lc}, rd);
    apb(1'b0, `REG_FRAMES_OFS, 32'h0000_0000, rd, err);
    chk("frames", nf, rd);
    apb(1'b1, `REG_STATUS_OFS, 32'h0000_0100, rd, err);
    apb(1'b0, `REG_STATUS_OFS, 32'h0000_0000, rd, err);
    chk("status clear", {24'h0, lc}, rd);
    apb(1'b1, `REG_CTRL_OFS, 32'h0000_0000, rd, err);
    repeat (2) @(posedge ref_clk);
    chk("rx gate", 32'h0000_0000, {31'h0, rxReady});
    apb(1'b0, `REG_CTRL_OFS, 32'h0000_0000, rd, err);
    chk("ctrl", 32'h0000_0000, rd);
    apb(1'b1, `REG_CTRL_OFS, 32'h0000_0001, rd, err);
    frame(`CMD_QUERY_AVAIL, 32'h0000_0000, 32'h0000_0000);
    final_report();
  end
endmodule : test_gpio_command_handler
